// ### rtl/dbr_pkg.sv
// holds the constants, codes and state types of the blink reporter
// assumes a single 10 MHz clock and an AXI4-Lite register port
// Operation
// - after power-up run self-tests; on failure blink the error code on LED.
// - fatal self-test failures halt in error blinking until power is cycled.
// - tests pass with jumper shorted: enter the repeating seek exercise loop.
// - tests pass with jumper open: sit idle awaiting interface control.
// - a fault during the seek exercise is blinked as its code.
// - codes cover faults at power-up, during exercise and in normal idle.
// - a zero bit is half a second of flashing LED.
// - a one bit is half a second of steady lit LED.
// - LED stays dark half a second between bits of a word.
// - words are five bits, repeats separated by one second dark.
// - code is sent most significant bit first.
// - RAM fault is 00, ROM checksum 01, interface chip 02.
// - stuck write fault is 03, unsafe write circuitry is 16.
// - missing index is 04, spindle speed out of tolerance is 05.
// - fine-track loss while idle is 06, more than one seek retry 07.
// - seek timeouts 08 and 09, post-seek faults 0A to 0D.
// - rezero pattern timeouts 10 to 12, 18 to 1A, post-rezero 1B to 1D.
// - unsafe voltage 14 gate idle, 15 gate active; steps in write 17.
// - unexpected interrupt 0F, trap 1F; reserved codes never sent.
// - seek-complete stays false for the whole seek.
// - actuator motion starts on the first step pulse.
package dbr_pkg;

  // ********************************
  // timing
  // ********************************
  localparam int CLK_HZ      = 10_000_000;
  localparam int BIT_MS      = 500;
  localparam int WORD_GAP_MS = 1000;
  localparam int FLASH_US    = 62_500;
  localparam int BIT_CYC     = BIT_MS * (CLK_HZ / 1000);
  localparam int WORD_CYC    = WORD_GAP_MS * (CLK_HZ / 1000);
  localparam int FLASH_CYC   = FLASH_US * (CLK_HZ / 1_000_000);
  localparam int CNT_W       = 24;
  localparam int CODE_BITS   = 5;

  // ********************************
  // error codes
  // ********************************
  localparam logic [4:0] CODE_RAM       = 5'h00;
  localparam logic [4:0] CODE_ROM       = 5'h01;
  localparam logic [4:0] CODE_IFCHIP    = 5'h02;
  localparam logic [4:0] CODE_FINE_IDLE = 5'h06;
  localparam logic [4:0] CODE_VOLT_IDLE = 5'h14;
  localparam logic [4:0] CODE_VOLT_WR   = 5'h15;
  localparam logic [4:0] CODE_STEP_WR   = 5'h17;
  // codes 0E, 13 and 1E are reserved
  localparam logic [31:0] CODE_LEGAL    = 32'hBFF7_BFFF;

  // ********************************
  // registers
  // ********************************
  localparam logic [3:0] ADDR_CTRL      = 4'h0;
  localparam logic [3:0] ADDR_STATUS    = 4'h4;
  localparam int         CTRL_ACK       = 0;
  localparam int         CTRL_HOLD      = 1;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  // ********************************
  // types
  // ********************************
  typedef enum logic [2:0] {
    ST_TEST   = 3'b000,
    ST_IDLE   = 3'b001,
    ST_EXER   = 3'b010,
    ST_REPORT = 3'b011,
    ST_HALT   = 3'b100
  } dbr_state_t;

  typedef enum logic [1:0] {
    BL_OFF  = 2'b00,
    BL_MARK = 2'b01,
    BL_GAP  = 2'b10
  } dbr_blink_t;

endpackage

// ### rtl/dbr_top.sv
// diagnostic supervisor with activity LED error blinker
// assumes fault inputs come from logic on clk; pins are asynchronous
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
module dbr_top #(
  parameter int BIT_CYC_P   = dbr_pkg::BIT_CYC,
  parameter int WORD_CYC_P  = dbr_pkg::WORD_CYC,
  parameter int FLASH_CYC_P = dbr_pkg::FLASH_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // internal status from same clock domain
  input  wire logic        selfTestDone,
  input  wire logic        ramFault,
  input  wire logic        romFault,
  input  wire logic        ifChipFault,
  input  wire logic [31:0] faultReq,
  input  wire logic        voltUnsafe,
  input  wire logic        seekDone,
  // asynchronous pins
  input  wire logic        diagExerciseJumper,
  input  wire logic        fineTrackFlag,
  input  wire logic        writeGateLineN,
  input  wire logic        stepPulseN,
  // drive outputs
  output logic             activityLed,
  output logic             seekComplete,
  output logic             motionStart,
  output logic             exerSeekReq,
  output logic             exerciseActive,
  // axi4-lite write
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import dbr_pkg::*;

  localparam int NPIN = 4;

  logic [NPIN-1:0]  pinRaw;
  logic [NPIN-1:0]  syncA_ff;
  logic [NPIN-1:0]  syncB_ff;
  logic [NPIN-1:0]  syncC_ff;
  logic [NPIN-1:0]  pinF_ff;
  logic [NPIN-1:0]  pinPrev_ff;
  logic             jumperF;
  logic             fineFall;
  logic             writeActive;
  logic             stepFall;
  dbr_state_t       state_ff;
  dbr_state_t       nxt_state;
  logic [4:0]       code_ff;
  logic [4:0]       nxt_code;
  logic             fatal_ff;
  logic [31:0]      evtVec;
  logic             evtAny;
  logic [4:0]       evtCode;
  dbr_blink_t       phase_ff;
  logic [2:0]       bitIdx_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] flashCnt_ff;
  logic             flashOn_ff;
  logic             reporting;
  logic             curBit;
  logic             markEnd;
  logic             gapEnd;
  logic             seekActive_ff;
  logic             exerHold_ff;
  logic             ackPulse;
  logic [3:0]       awAddr_ff;
  logic [31:0]      wData_ff;
  logic [3:0]       wStrb_ff;
  logic             awHeld_ff;
  logic             wHeld_ff;
  logic             doWrite;

  // ********************************
  // pin synchronisers
  // ********************************
  assign pinRaw = {stepPulseN, writeGateLineN, fineTrackFlag,
                   diagExerciseJumper};

  // a change is taken only once the last two stages agree
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          syncA_ff[gi] <= 1'b0;
          syncB_ff[gi] <= 1'b0;
          syncC_ff[gi] <= 1'b0;
          pinF_ff[gi]  <= 1'b0;
        end else begin
          syncA_ff[gi] <= pinRaw[gi];
          syncB_ff[gi] <= syncA_ff[gi];
          syncC_ff[gi] <= syncB_ff[gi];
          if (syncB_ff[gi] == syncC_ff[gi]) begin
            pinF_ff[gi] <= syncC_ff[gi];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pinPrev_ff <= '0;
    end else begin
      pinPrev_ff <= pinF_ff;
    end
  end

  assign jumperF     = pinF_ff[0];
  assign fineFall    = pinPrev_ff[1] & ~pinF_ff[1];
  assign writeActive = ~pinF_ff[2];
  assign stepFall    = pinPrev_ff[3] & ~pinF_ff[3];

  // ********************************
  // fault collection
  // ********************************
  always_comb begin
    evtVec = faultReq & CODE_LEGAL;
    if (voltUnsafe) begin
      evtVec[writeActive ? CODE_VOLT_WR : CODE_VOLT_IDLE] = 1'b1;
    end
    if (stepFall && writeActive) begin
      evtVec[CODE_STEP_WR] = 1'b1;
    end
    if (fineFall && state_ff == ST_IDLE) begin
      evtVec[CODE_FINE_IDLE] = 1'b1;
    end
  end

  // lowest pending code wins when several arrive together
  always_comb begin
    evtCode = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (evtVec[i]) begin
        evtCode = 5'(i);
      end
    end
  end

  assign evtAny = |evtVec;

  // ********************************
  // supervisor
  // ********************************
  always_comb begin
    nxt_state = state_ff;
    nxt_code  = code_ff;
    case (state_ff)
      ST_TEST: begin
        if (selfTestDone) begin
          if (ramFault) begin
            nxt_state = ST_HALT;
            nxt_code  = CODE_RAM;
          end else if (romFault) begin
            nxt_state = ST_HALT;
            nxt_code  = CODE_ROM;
          end else if (ifChipFault) begin
            nxt_state = ST_HALT;
            nxt_code  = CODE_IFCHIP;
          end else if (jumperF) begin
            nxt_state = ST_EXER;
          end else begin
            nxt_state = ST_IDLE;
          end
        end
      end
      ST_IDLE, ST_EXER: begin
        if (evtAny) begin
          nxt_state = ST_REPORT;
          nxt_code  = evtCode;
        end
      end
      ST_REPORT: begin
        if (ackPulse) begin
          nxt_state = jumperF ? ST_EXER : ST_IDLE;
        end
      end
      ST_HALT: begin
        nxt_state = ST_HALT;
      end
      default: begin
        nxt_state = ST_TEST;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_TEST;
      code_ff  <= 5'h00;
    end else begin
      state_ff <= nxt_state;
      code_ff  <= nxt_code;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fatal_ff <= 1'b0;
    end else if (nxt_state == ST_HALT) begin
      fatal_ff <= 1'b1;
    end
  end

  // ********************************
  // code blinker
  // ********************************
  assign reporting = (state_ff == ST_REPORT) || (state_ff == ST_HALT);
  assign curBit    = code_ff[bitIdx_ff];
  assign markEnd   = cnt_ff == CNT_W'(BIT_CYC_P - 1);
  assign gapEnd    = (bitIdx_ff == 3'd0) ?
                     (cnt_ff == CNT_W'(WORD_CYC_P - 1)) : markEnd;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_ff  <= BL_OFF;
      bitIdx_ff <= 3'd4;
      cnt_ff    <= '0;
    end else if (!reporting) begin
      phase_ff  <= BL_OFF;
      bitIdx_ff <= 3'd4;
      cnt_ff    <= '0;
    end else begin
      case (phase_ff)
        BL_OFF: begin
          phase_ff  <= BL_MARK;
          bitIdx_ff <= 3'(CODE_BITS - 1);
          cnt_ff    <= '0;
        end
        BL_MARK: begin
          if (markEnd) begin
            phase_ff <= BL_GAP;
            cnt_ff   <= '0;
          end else begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
        BL_GAP: begin
          if (gapEnd) begin
            phase_ff  <= BL_MARK;
            cnt_ff    <= '0;
            bitIdx_ff <= (bitIdx_ff == 3'd0) ?
                         3'(CODE_BITS - 1) : bitIdx_ff - 3'd1;
          end else begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
        default: begin
          phase_ff <= BL_OFF;
        end
      endcase
    end
  end

  // flash phase restarts lit at every mark so each zero looks alike
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flashCnt_ff <= '0;
      flashOn_ff  <= 1'b1;
    end else if (phase_ff != BL_MARK) begin
      flashCnt_ff <= '0;
      flashOn_ff  <= 1'b1;
    end else if (flashCnt_ff == CNT_W'(FLASH_CYC_P - 1)) begin
      flashCnt_ff <= '0;
      flashOn_ff  <= ~flashOn_ff;
    end else begin
      flashCnt_ff <= flashCnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      activityLed <= 1'b0;
    end else if (phase_ff == BL_MARK) begin
      activityLed <= curBit ? 1'b1 : flashOn_ff;
    end else begin
      activityLed <= 1'b0;
    end
  end

  // ********************************
  // seek tracking and exercise
  // ********************************
  // a new start in the same cycle as seekDone keeps the seek open
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      seekActive_ff <= 1'b0;
    end else if (stepFall || exerSeekReq) begin
      seekActive_ff <= 1'b1;
    end else if (seekDone) begin
      seekActive_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      seekComplete   <= 1'b0;
      motionStart    <= 1'b0;
      exerSeekReq    <= 1'b0;
      exerciseActive <= 1'b0;
    end else begin
      seekComplete   <= ~seekActive_ff & ~stepFall & ~exerSeekReq;
      motionStart    <= (stepFall || exerSeekReq) && !seekActive_ff;
      exerSeekReq    <= (state_ff == ST_EXER) && !seekActive_ff &&
                        !exerSeekReq && !exerHold_ff;
      exerciseActive <= state_ff == ST_EXER;
    end
  end

  // ********************************
  // register port
  // ********************************
  assign s_axi_awready = ~awHeld_ff;
  assign s_axi_wready  = ~wHeld_ff;
  assign s_axi_arready = ~s_axi_rvalid;
  assign doWrite       = awHeld_ff & wHeld_ff & ~s_axi_bvalid;
  assign ackPulse      = doWrite && awAddr_ff == ADDR_CTRL &&
                         wStrb_ff[0] && wData_ff[CTRL_ACK];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awHeld_ff <= 1'b0;
      awAddr_ff <= 4'h0;
    end else if (s_axi_awvalid && !awHeld_ff) begin
      awHeld_ff <= 1'b1;
      awAddr_ff <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wHeld_ff <= 1'b0;
      wData_ff <= 32'h0000_0000;
      wStrb_ff <= 4'h0;
    end else if (s_axi_wvalid && !wHeld_ff) begin
      wHeld_ff <= 1'b1;
      wData_ff <= s_axi_wdata;
      wStrb_ff <= s_axi_wstrb;
    end else if (doWrite) begin
      wHeld_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      if (awAddr_ff == ADDR_CTRL || awAddr_ff == ADDR_STATUS) begin
        s_axi_bresp <= RESP_OKAY;
      end else begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      exerHold_ff <= 1'b0;
    end else if (doWrite && awAddr_ff == ADDR_CTRL && wStrb_ff[0]) begin
      exerHold_ff <= wData_ff[CTRL_HOLD];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      if (s_axi_araddr == ADDR_CTRL) begin
        s_axi_rdata <= {30'h0, exerHold_ff, 1'b0};
      end else if (s_axi_araddr == ADDR_STATUS) begin
        s_axi_rdata <= {20'h0, seekActive_ff, state_ff, activityLed,
                        fatal_ff, reporting, code_ff};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ********************************
  // assertions
  // ********************************
  property p_halt_sticky;
    @(posedge clk) disable iff (!rstn)
    state_ff == ST_HALT |=> state_ff == ST_HALT && code_ff == $past(code_ff);
  endproperty
  a_halt_sticky: assert property (p_halt_sticky)
    else $error("halt state left or code changed");

  property p_ram_code;
    @(posedge clk) disable iff (!rstn)
    state_ff == ST_TEST && selfTestDone && ramFault
      |=> state_ff == ST_HALT && code_ff == 5'h00 ##1 phase_ff == BL_MARK;
  endproperty
  a_ram_code: assert property (p_ram_code)
    else $error("ram fault not halted with code 00");

  property p_jumper_exer;
    @(posedge clk) disable iff (!rstn)
    state_ff == ST_TEST && selfTestDone && !(ramFault || romFault ||
      ifChipFault) |=> state_ff == ($past(jumperF) ? ST_EXER : ST_IDLE);
  endproperty
  a_jumper_exer: assert property (p_jumper_exer)
    else $error("jumper did not select the mode");

  property p_fault_report;
    @(posedge clk) disable iff (!rstn)
    state_ff == ST_EXER && evtAny |=> state_ff == ST_REPORT ##1 reporting;
  endproperty
  a_fault_report: assert property (p_fault_report)
    else $error("exercise fault not reported");

  property p_gap_dark;
    @(posedge clk) disable iff (!rstn)
    phase_ff == BL_GAP |=> !activityLed;
  endproperty
  a_gap_dark: assert property (p_gap_dark)
    else $error("led lit between bits");

  property p_one_steady;
    @(posedge clk) disable iff (!rstn)
    reporting && phase_ff == BL_MARK && curBit && !markEnd
      |=> activityLed [*2];
  endproperty
  a_one_steady: assert property (p_one_steady)
    else $error("one bit not steady");

  property p_flash_toggle;
    @(posedge clk) disable iff (!rstn)
    reporting && phase_ff == BL_MARK && !curBit && !markEnd &&
      flashCnt_ff == CNT_W'(FLASH_CYC_P - 1)
      |=> flashOn_ff != $past(flashOn_ff) ##1 activityLed == $past(flashOn_ff);
  endproperty
  a_flash_toggle: assert property (p_flash_toggle)
    else $error("zero bit not flashing");

  property p_word_wrap;
    @(posedge clk) disable iff (!rstn)
    phase_ff == BL_GAP && bitIdx_ff == 3'd0 &&
      cnt_ff == CNT_W'(WORD_CYC_P - 1) && reporting
      |=> phase_ff == BL_MARK && bitIdx_ff == 3'd4;
  endproperty
  a_word_wrap: assert property (p_word_wrap)
    else $error("word did not restart at msb after long gap");

  property p_no_reserved;
    @(posedge clk) disable iff (!rstn)
    reporting |-> CODE_LEGAL[code_ff];
  endproperty
  a_no_reserved: assert property (p_no_reserved)
    else $error("reserved code reported");

  property p_seek_false;
    @(posedge clk) disable iff (!rstn)
    seekActive_ff |=> !seekComplete;
  endproperty
  a_seek_false: assert property (p_seek_false)
    else $error("seek complete true during seek");

  property p_first_step;
    @(posedge clk) disable iff (!rstn)
    stepFall && !seekActive_ff |=> motionStart && seekActive_ff;
  endproperty
  a_first_step: assert property (p_first_step)
    else $error("motion not started on first step");

endmodule

// ### verification/dbr_led_watch.sv
// operator model: decodes activity LED words, counts timing faults
// assumes reduced blink counts and the bench clock
`timescale 1ns/100ps
module dbr_led_watch #(
  parameter int BIT   = 40,
  parameter int WORD  = 80,
  parameter int FLASH = 5
) (
  // ********
  // clock
  // ********
  input  wire logic clk,
  input  wire logic rstn,
  // ********
  // lamp and results
  // ********
  input  wire logic led,
  output int        code,
  output int        words,
  output int        errs
);
  // a zero ends on its last lit flash, so its lit span may be short
  localparam int ZSPAN = ((BIT / FLASH - 1) / 2 * 2 + 1) * FLASH;
  localparam int ZRISE = (BIT / FLASH + 1) / 2;
  int         dark, start, last, rises, nBits, t, trail;
  logic       ledQ, wrapped;
  logic [4:0] sh;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {dark, start, last, rises, nBits, t, trail} = '0;
      wrapped = 1'b0;
      {code, words, errs} = '0;
      ledQ = 1'b0;
      sh = '0;
    end else begin
      t = t + 1;
      if (led) begin
        if (!ledQ) begin
          if (rises == 0) begin
            start = t;
            // first rise after an entry has no gap to judge
            if (nBits > 0 && dark != BIT + trail) errs++;
            if (nBits == 0 && wrapped && dark != WORD + trail) errs++;
            wrapped = 1'b0;
          end else if (dark != FLASH) errs++;
          rises++;
        end
        last = t;
        dark = 0;
      end else if (dark < 4 * WORD) dark++;
      if (dark > WORD + BIT) wrapped = 1'b0;
      if (!led && dark == BIT / 2 && rises > 0) begin
        if (rises == 1 && last - start + 1 != BIT) errs++;
        if (rises > 1 && (last - start + 1 != ZSPAN || rises != ZRISE))
          errs++;
        trail = (rises == 1) ? 0 : BIT - ZSPAN;
        sh = {sh[3:0], rises == 1};
        nBits++;
        rises = 0;
      end
      if (!led && dark == BIT + BIT / 2) begin
        if (nBits == 5) begin
          code = sh;
          words++;
          wrapped = 1'b1;
        end
        nBits = 0;
      end
      ledQ = led;
    end
  end
endmodule

// ### verification/dbr_top_tb_top.sv
// bench for the blink reporter: bus tasks, code model, scenarios
// assumes reduced blink counts; LED decoded by dbr_led_watch
`timescale 1ns/100ps
module dbr_top_tb_top;
  import dbr_pkg::*;
  localparam int BIT = 40, WORD = 80, FLASH = 5;
  logic        clk, rstn, stDone, ram, rom, ifc, volt, sDone;
  logic        jmp, fine, wgN, stepN, led, sc, ms, esr, exAct;
  logic        awV, awR, wV, wR, bV, bR, arV, arR, rV, rR;
  logic [3:0]  awA, arA, wS;
  logic [1:0]  bResp, rResp, rsp;
  logic [31:0] fReq, wd, rd, rdata, lfsrV;
  int          fails, checks_done, cyc, code, words, errs, e0, k, n;
  int          expPin[4] = '{6, 20, 21, 23};

  dbr_top #(.BIT_CYC_P(BIT), .WORD_CYC_P(WORD), .FLASH_CYC_P(FLASH)) uut (
    .clk(clk), .rstn(rstn), .selfTestDone(stDone), .ramFault(ram),
    .romFault(rom), .ifChipFault(ifc), .faultReq(fReq), .voltUnsafe(volt),
    .seekDone(sDone), .diagExerciseJumper(jmp), .fineTrackFlag(fine),
    .writeGateLineN(wgN), .stepPulseN(stepN), .activityLed(led),
    .seekComplete(sc), .motionStart(ms), .exerSeekReq(esr),
    .exerciseActive(exAct), .s_axi_awaddr(awA), .s_axi_awvalid(awV),
    .s_axi_awready(awR), .s_axi_wdata(wd), .s_axi_wstrb(wS),
    .s_axi_wvalid(wV), .s_axi_wready(wR), .s_axi_bresp(bResp),
    .s_axi_bvalid(bV), .s_axi_bready(bR), .s_axi_araddr(arA),
    .s_axi_arvalid(arV), .s_axi_arready(arR), .s_axi_rdata(rdata),
    .s_axi_rresp(rResp), .s_axi_rvalid(rV), .s_axi_rready(rR));

  dbr_led_watch #(.BIT(BIT), .WORD(WORD), .FLASH(FLASH)) watch (
    .clk(clk), .rstn(rstn), .led(led), .code(code), .words(words),
    .errs(errs));

  // ********
  // helpers
  // ********
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic conclude();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end

  task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
    checks_done++;
    if (got !== ex) begin
      fails++;
      $display("[FAIL] %s exp %0h got %0h", nm, ex, got);
    end
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // reserved codes never reported
  function automatic int model(input int c);
    if (c == 5'h0E || c == 5'h13 || c == 5'h1E) return -1;
    return c;
  endfunction

  // handshakes judged from values held just before the edge
  task automatic axiWr(logic [3:0] a, logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tk;
    awA <= a; wd <= d; wS <= 4'hF; awV <= 1'b1; wV <= 1'b1; bR <= 1'b1;
    do begin
      @(negedge clk);
      ta = awV && awR;
      tw = wV && wR;
      tk = bV && bR;
      r = bResp;
      @(posedge clk);
      if (ta) awV <= 1'b0;
      if (tw) wV <= 1'b0;
    end while (!tk);
    bR <= 1'b0;
    @(posedge clk);
  endtask

  task automatic axiRd(logic [3:0] a, output logic [31:0] d,
                       output logic [1:0] r);
    logic ta, tk;
    arA <= a; arV <= 1'b1; rR <= 1'b1;
    do begin
      @(negedge clk);
      ta = arV && arR;
      tk = rV && rR;
      d = rdata;
      r = rResp;
      @(posedge clk);
      if (ta) arV <= 1'b0;
    end while (!tk);
    rR <= 1'b0;
    @(posedge clk);
  endtask

  task automatic stat(int st, int c);
    axiRd(ADDR_STATUS, rd, rsp);
    chk("state", st, rd[10:8]);
    if (c >= 0) chk("code", c, rd[4:0]);
  endtask

  task automatic ack();
    axiWr(ADDR_CTRL, 32'h1, rsp);
  endtask

  task automatic fault(int c);
    fReq[c] <= 1'b1;
    @(posedge clk);
    fReq <= '0;
    repeat (2) @(posedge clk);
  endtask

  task automatic boot(logic j, logic [2:0] f);
    rstn <= 1'b0;
    jmp <= j;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    {ram, rom, ifc} <= f;
    stDone <= 1'b1;
    @(posedge clk);
    stDone <= 1'b0;
    {ram, rom, ifc} <= 3'h0;
    repeat (2) @(posedge clk);
  endtask

  task automatic waitHi(ref logic s);
    n = 0;
    while (s !== 1'b1 && n < 12) begin
      @(posedge clk);
      n++;
    end
  endtask

  // ********
  // scenarios
  // ********
  initial begin
    rstn = 1'b0; stDone = 1'b0; {ram, rom, ifc} = 3'h0; volt = 1'b0;
    sDone = 1'b0; jmp = 1'b0; fine = 1'b1; wgN = 1'b1; stepN = 1'b1;
    {awV, wV, bR, arV, rR} = 5'h0; awA = '0; arA = '0; wS = '0;
    fReq = '0; wd = '0; lfsrV = 32'h1451;
    @(posedge clk);
    boot(1'b0, 3'h0);
    stat(1, -1);
    chk("seekComplete", 1, sc);
    axiRd(4'h8, rd, rsp);
    chk("rresp", RESP_SLVERR, rsp);
    axiWr(4'hC, 32'h0, rsp);
    chk("bresp", RESP_SLVERR, rsp);
    $display("test idle done");
    e0 = errs;
    fault(26);
    stat(3, 26);
    while (words < 2) @(posedge clk);
    chk("ledCode", 26, code);
    chk("ledTiming", e0, errs);
    ack();
    stat(1, -1);
    $display("test blink done");
    for (k = 0; k < 6; k++) begin
      lfsrV = lfsr(lfsrV);
      n = (k == 0) ? 14 : 3 + int'(lfsrV[4:0]) % 29;
      while (n == 6 || n == 20 || n == 21 || n == 23) n++;
      fault(n);
      stat(model(n) < 0 ? 1 : 3, model(n));
      if (model(n) >= 0) ack();
    end
    $display("test codes done");
    for (k = 0; k < 4; k++) begin
      wgN <= (k < 2);
      repeat (8) @(posedge clk);
      fine <= (k != 0);
      volt <= (k == 1 || k == 2);
      stepN <= (k != 3);
      repeat (8) @(posedge clk);
      stat(3, expPin[k]);
      fine <= 1'b1;
      volt <= 1'b0;
      stepN <= 1'b1;
      repeat (8) @(posedge clk);
      ack();
    end
    wgN <= 1'b1;
    $display("test pins done");
    boot(1'b1, 3'h0);
    chk("exerciseActive", 1, exAct);
    waitHi(esr);
    chk("exerSeekReq", 1, esr);
    waitHi(ms);
    chk("motionStart", 1, ms);
    axiWr(ADDR_CTRL, 32'h2, rsp);
    chk("seekComplete", 0, sc);
    sDone <= 1'b1;
    @(posedge clk);
    sDone <= 1'b0;
    repeat (3) @(posedge clk);
    chk("seekComplete", 1, sc);
    stepN <= 1'b0;
    waitHi(ms);
    chk("motionStart", 1, ms);
    stepN <= 1'b1;
    n = 0;
    repeat (10) begin
      @(posedge clk);
      n += sc;
    end
    chk("seekLow", 0, n);
    sDone <= 1'b1;
    @(posedge clk);
    sDone <= 1'b0;
    fault(8);
    stat(3, 8);
    $display("test exercise done");
    for (k = 0; k < 3; k++) begin
      boot(1'b0, 3'h7 >> k);
      e0 = errs;
      ack();
      stat(4, k);
      while (words < 2) @(posedge clk);
      chk("ledCode", k, code);
      chk("ledTiming", e0, errs);
    end
    $display("test halt done");
    conclude();
  end
endmodule
